// file: common/lcb_pkg.sv
// Constants for the middle control bits of the link main control register
package lcb_pkg;
  localparam logic [7:0] LCB_CTRL_OFS = 8'h08;
  // Bit n of the register sits at hardware position 31-n
  localparam int LCB_IDLE_POS = 22;
  localparam int LCB_TXRST_POS = 21;
  localparam int LCB_RXRST_POS = 20;
  localparam int LCB_CSTAT_POS = 19;
  localparam int LCB_CDIS_POS = 18;
  localparam int LCB_BNCLR_POS = 16;
  localparam int LCB_DIVA_POS = 15;
  localparam int LCB_DIVB_POS = 14;
  localparam int LCB_MVACK_POS = 13;
  localparam int LCB_FFACK_POS = 12;
  localparam logic LCB_CDIS_RST = 1'b1;
  localparam logic LCB_BIT_RST = 1'b0;
  localparam logic [1:0] LCB_DIV_RST = 2'h0;
  localparam logic [1:0] LCB_DIV_16 = 2'h0;
  localparam logic [1:0] LCB_DIV_2 = 2'h1;
  localparam logic [1:0] LCB_DIV_4 = 2'h2;
  localparam logic [1:0] LCB_DIV_32 = 2'h3;
  localparam logic [4:0] LCB_HALF_16 = 5'h08;
  localparam logic [4:0] LCB_HALF_2 = 5'h01;
  localparam logic [4:0] LCB_HALF_4 = 5'h02;
  localparam logic [4:0] LCB_HALF_32 = 5'h10;
  localparam logic [3:0] LCB_ACK_COMPLETE = 4'h1;
  localparam logic [3:0] LCB_ACK_PENDING = 4'h2;
  localparam logic [2:0] LCB_HSIZE_WORD = 3'h2;
endpackage : lcb_pkg

// file: common/lcb_lps_if.sv
// Carrier between the control register and the power-status clock divider
`timescale 1ns/1ps
interface lcb_lps_if;
  logic [1:0] divisor;
  logic lps;
  modport ctrl (output divisor, input lps);
  modport gen (input divisor, output lps);
endinterface : lcb_lps_if

// file: rtl/lcb_lps_div.sv
// Link-power-status clock divider
`timescale 1ns/1ps
module lcb_lps_div
  import lcb_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  lcb_lps_if.gen lps_bus
);
  logic [4:0] cnt_ff;
  logic lps_ff;
  logic [4:0] half;

  always_comb begin
    unique case (lps_bus.divisor)
      LCB_DIV_16: half = LCB_HALF_16;
      LCB_DIV_2: half = LCB_HALF_2;
      LCB_DIV_4: half = LCB_HALF_4;
      LCB_DIV_32: half = LCB_HALF_32;
    endcase
  end

  // Toggle every half period; a larger count after a code change restarts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 5'h00;
      lps_ff <= 1'b0;
    end else if (cnt_ff >= half - 5'h01) begin
      cnt_ff <= 5'h00;
      lps_ff <= ~lps_ff;
    end else begin
      cnt_ff <= cnt_ff + 5'h01;
    end
  end

  assign lps_bus.lps = lps_ff;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  lps_div2_a: assert property (
    lps_bus.divisor == LCB_DIV_2 && $past(lps_bus.divisor) == LCB_DIV_2
      |-> $changed(lps_ff))
    else $error("power clock not toggling every cycle at divide by 2");
  lps_div16_a: assert property (
    $changed(lps_ff) && lps_bus.divisor == LCB_DIV_16
      && $past(lps_bus.divisor) == LCB_DIV_16
      |=> ($stable(lps_ff) && lps_bus.divisor == LCB_DIV_16)[*7]
      ##1 $changed(lps_ff) or ##[1:8] lps_bus.divisor != LCB_DIV_16)
    else $error("power clock half period wrong at divide by 16");
endmodule : lcb_lps_div

// file: rtl/lcb_link_ctrl_mid.sv
// Middle control bits of the link main control register, AHB-Lite slave
`timescale 1ns/1ps
module lcb_link_ctrl_mid
  import lcb_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic idle_insert_enable,
  input wire logic phy_grant,
  output logic phy_idle_drive,
  output logic transmitter_soft_reset,
  output logic receiver_soft_reset,
  input wire logic contender_pin_in,
  output logic contender_pin_out,
  output logic contender_pin_oe,
  input wire logic local_bus_reset,
  output logic bus_number_clear,
  output logic link_power_status_clock,
  input wire logic async_to_mover,
  input wire logic async_to_fifo,
  input wire logic async_is_write,
  output logic ack_valid,
  output logic [3:0] ack_code
);
  if (ADDR_W < 8) begin : g_chk
    $error("ADDR_W must be at least 8 to reach the control register");
  end

  lcb_lps_if lps_bus ();

  // Bus tracking
  logic hreadyout_ff;
  logic hrdata_ff_en;
  logic [31:0] hrdata_ff;
  logic wr_pend_ff;
  logic hit_ff;
  logic acc;
  logic addr_hit;
  logic wr_do;

  // Control bits
  logic idle_ff;
  logic txrst_ff;
  logic rxrst_ff;
  logic cstat_ff;
  logic cdis_ff;
  logic bnclr_ff;
  logic [1:0] div_ff;
  logic mvack_ff;
  logic ffack_ff;
  logic nxt_idle;
  logic nxt_cstat;
  logic nxt_cdis;
  logic nxt_bnclr;
  logic [1:0] nxt_div;
  logic nxt_mvack;
  logic nxt_ffack;
  logic [31:0] rd_word;

  // Side outputs
  logic idle_drive_ff;
  logic cpin_out_ff;
  logic cpin_oe_ff;
  logic bus_clr_ff;
  logic ack_valid_ff;
  logic [3:0] ack_code_ff;

  assign acc = hsel && htrans[1] && hready;
  // Full decode, so the register has no aliases higher up
  assign addr_hit = haddr == ADDR_W'(LCB_CTRL_OFS);
  assign wr_do = wr_pend_ff && hit_ff;

  // Address phase capture; slave never waits and always answers OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      hit_ff <= 1'b0;
      hreadyout_ff <= 1'b1;
    end else begin
      wr_pend_ff <= acc && hwrite && hsize == LCB_HSIZE_WORD;
      hit_ff <= acc && addr_hit;
      hreadyout_ff <= 1'b1;
    end
  end

  // Next values, so a read right after a write sees the new contents
  always_comb begin
    nxt_idle = idle_ff;
    nxt_bnclr = bnclr_ff;
    nxt_div = div_ff;
    nxt_mvack = mvack_ff;
    nxt_ffack = ffack_ff;
    nxt_cdis = cdis_ff;
    if (wr_do) begin
      nxt_idle = hwdata[LCB_IDLE_POS];
      nxt_bnclr = hwdata[LCB_BNCLR_POS];
      nxt_div = {hwdata[LCB_DIVA_POS], hwdata[LCB_DIVB_POS]};
      nxt_mvack = hwdata[LCB_MVACK_POS];
      nxt_ffack = hwdata[LCB_FFACK_POS];
      nxt_cdis = hwdata[LCB_CDIS_POS];
    end
  end

  // Sensed from the pin while the driver is off, else software's value
  always_comb begin
    if (cdis_ff) begin
      nxt_cstat = contender_pin_in;
    end else if (wr_do) begin
      nxt_cstat = hwdata[LCB_CSTAT_POS];
    end else begin
      nxt_cstat = cstat_ff;
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_word[LCB_IDLE_POS] = nxt_idle;
    rd_word[LCB_CSTAT_POS] = nxt_cstat;
    rd_word[LCB_CDIS_POS] = nxt_cdis;
    rd_word[LCB_BNCLR_POS] = nxt_bnclr;
    rd_word[LCB_DIVA_POS] = nxt_div[1];
    rd_word[LCB_DIVB_POS] = nxt_div[0];
    rd_word[LCB_MVACK_POS] = nxt_mvack;
    rd_word[LCB_FFACK_POS] = nxt_ffack;
  end

  // Reset bits read 0; unmapped addresses read 0
  assign hrdata_ff_en = acc && !hwrite;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (hrdata_ff_en) begin
      hrdata_ff <= addr_hit ? rd_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_ff <= LCB_BIT_RST;
      bnclr_ff <= LCB_BIT_RST;
      div_ff <= LCB_DIV_RST;
      mvack_ff <= LCB_BIT_RST;
      ffack_ff <= LCB_BIT_RST;
    end else begin
      idle_ff <= nxt_idle;
      bnclr_ff <= nxt_bnclr;
      div_ff <= nxt_div;
      mvack_ff <= nxt_mvack;
      ffack_ff <= nxt_ffack;
    end
  end

  // Contender status and driver
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cdis_ff <= LCB_CDIS_RST;
      cstat_ff <= LCB_BIT_RST;
      cpin_out_ff <= 1'b0;
      cpin_oe_ff <= 1'b0;
    end else begin
      cdis_ff <= nxt_cdis;
      cstat_ff <= nxt_cstat;
      cpin_out_ff <= nxt_cstat;
      cpin_oe_ff <= !nxt_cdis;
    end
  end

  // Self-clearing resets: one-cycle pulse after the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txrst_ff <= 1'b0;
      rxrst_ff <= 1'b0;
    end else begin
      txrst_ff <= wr_do && hwdata[LCB_TXRST_POS];
      rxrst_ff <= wr_do && hwdata[LCB_RXRST_POS];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_drive_ff <= 1'b0;
    end else begin
      idle_drive_ff <= phy_grant && idle_ff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_clr_ff <= 1'b0;
    end else begin
      bus_clr_ff <= local_bus_reset && bnclr_ff;
    end
  end

  // Acknowledge code for routed asynchronous packets; mover port wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_valid_ff <= 1'b0;
      ack_code_ff <= LCB_ACK_PENDING;
    end else begin
      ack_valid_ff <= async_to_mover || async_to_fifo;
      if (async_to_mover) begin
        ack_code_ff <= (mvack_ff && async_is_write)
          ? LCB_ACK_COMPLETE : LCB_ACK_PENDING;
      end else if (async_to_fifo) begin
        ack_code_ff <= ffack_ff
          ? LCB_ACK_COMPLETE : LCB_ACK_PENDING;
      end
    end
  end

  assign lps_bus.divisor = div_ff;

  lcb_lps_div u_lps_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .lps_bus(lps_bus)
  );

  assign hreadyout = hreadyout_ff;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign idle_insert_enable = idle_ff;
  assign phy_idle_drive = idle_drive_ff;
  assign transmitter_soft_reset = txrst_ff;
  assign receiver_soft_reset = rxrst_ff;
  assign contender_pin_out = cpin_out_ff;
  assign contender_pin_oe = cpin_oe_ff;
  assign bus_number_clear = bus_clr_ff;
  assign link_power_status_clock = lps_bus.lps;
  assign ack_valid = ack_valid_ff;
  assign ack_code = ack_code_ff;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  idle_drive_a: assert property (
    phy_grant && idle_insert_enable |=> phy_idle_drive)
    else $error("idle not driven after grant");
  idle_quiet_a: assert property (
    !idle_insert_enable |=> !phy_idle_drive)
    else $error("idle driven while insertion disabled");
  tx_reset_a: assert property (
    wr_do && hwdata[LCB_TXRST_POS]
      |=> transmitter_soft_reset ##1 !transmitter_soft_reset)
    else $error("transmitter reset pulse wrong");
  rx_reset_a: assert property (
    wr_do && hwdata[LCB_RXRST_POS]
      |=> receiver_soft_reset ##1 !receiver_soft_reset)
    else $error("receiver reset pulse wrong");
  ctnd_sense_a: assert property (
    cdis_ff |=> cstat_ff == $past(contender_pin_in))
    else $error("contender status not following pin");
  ctnd_drive_a: assert property (
    !cdis_ff && !wr_do |=> contender_pin_oe
      && contender_pin_out == $past(cstat_ff))
    else $error("contender pin not driven from status");
  ctnd_reset_a: assert property (
    $rose(hresetn) |-> !contender_pin_oe && cdis_ff)
    else $error("contender driver not off after reset");
  bus_clear_a: assert property (
    local_bus_reset && bnclr_ff |=> bus_number_clear)
    else $error("bus number not cleared on bus reset");
  mover_ack_a: assert property (
    async_to_mover && !(mvack_ff && async_is_write)
      |=> ack_valid && ack_code == LCB_ACK_PENDING)
    else $error("mover port ack not pending");
  fifo_ack_a: assert property (
    async_to_fifo && !async_to_mover
      |=> ack_valid && ack_code
        == ($past(ffack_ff) ? LCB_ACK_COMPLETE : LCB_ACK_PENDING))
    else $error("receive FIFO ack code wrong");
  unmapped_read_a: assert property (
    acc && !hwrite && !addr_hit |=> hrdata == 32'h0000_0000)
    else $error("unmapped address read not zero");
  reset_reads_zero_a: assert property (
    acc && !hwrite |=> hrdata[LCB_TXRST_POS] == 1'b0
      && hrdata[LCB_RXRST_POS] == 1'b0)
    else $error("self-clearing reset bit read back as one");

  ctrl_write_c: cover property (wr_do ##1 acc && !hwrite && addr_hit);
  tx_reset_c: cover property (transmitter_soft_reset);
  ctnd_drive_c: cover property ($rose(contender_pin_oe));
  ack_complete_c: cover property (ack_valid
    && ack_code == LCB_ACK_COMPLETE);
endmodule : lcb_link_ctrl_mid

// file: sim/lcb_phy_model.sv
// PHY-side model: contender pin, grant and local bus reset
`timescale 1ns/1ps
module lcb_phy_model (
  input wire logic hclk,
  input wire logic pin_oe,
  input wire logic pin_out,
  output logic pin_in,
  output logic phy_grant,
  output logic local_bus_reset
);
  logic pin_level = 1'b1;
  // Link driver wins the pin, else the PHY's own level shows
  assign pin_in = pin_oe ? pin_out : pin_level;
  initial begin
    phy_grant = 1'b0;
    local_bus_reset = 1'b0;
  end
  task automatic grant_pulse(input int n);
    phy_grant <= 1'b1;
    repeat (n) @(posedge hclk);
    phy_grant <= 1'b0;
  endtask : grant_pulse
  task automatic bus_reset_pulse(input int n);
    local_bus_reset <= 1'b1;
    repeat (n) @(posedge hclk);
    local_bus_reset <= 1'b0;
  endtask : bus_reset_pulse
endmodule : lcb_phy_model

// file: sim/tb_top.sv
// Self-checking bench for the middle link control bits
`timescale 1ns/1ps
module tb_top;
  import lcb_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic idle_insert_enable, phy_grant, phy_idle_drive;
  logic transmitter_soft_reset, receiver_soft_reset, local_bus_reset;
  logic contender_pin_in, contender_pin_out, contender_pin_oe;
  logic bus_number_clear, link_power_status_clock, ack_valid;
  logic async_to_mover, async_to_fifo, async_is_write;
  logic [3:0] ack_code;
  int miscompares = 0;
  int samples_checked = 0;

  lcb_link_ctrl_mid i_lcb_link_ctrl_mid (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .idle_insert_enable, .phy_grant,
    .phy_idle_drive, .transmitter_soft_reset, .receiver_soft_reset,
    .contender_pin_in, .contender_pin_out, .contender_pin_oe,
    .local_bus_reset, .bus_number_clear, .link_power_status_clock,
    .async_to_mover, .async_to_fifo, .async_is_write, .ack_valid,
    .ack_code);
  lcb_phy_model i_lcb_phy_model (.hclk, .pin_oe(contender_pin_oe),
    .pin_out(contender_pin_out), .pin_in(contender_pin_in),
    .phy_grant, .local_bus_reset);

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : tick

  task automatic ahb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [2:0] sz);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask : ahb

  // Write, then a read address phase during the write's data phase
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] e);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b1;
    hsize <= LCB_HSIZE_WORD;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hwrite <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    chk(hrdata, e);
  endtask : wr_rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, LCB_HSIZE_WORD);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000, LCB_HSIZE_WORD);
    chk(rd, e);
  endtask : rdchk

  task automatic t_reset;
    #1;
    chk(contender_pin_oe, 1'b0);
    rdchk(8'h08, 32'h000c_0000);
  endtask : t_reset

  task automatic t_map;
    wr(8'h0c, 32'hffff_ffff);
    rdchk(8'h0c, 32'h0000_0000);
    ahb(1'b1, 8'h08, 32'h0040_0000, 3'h0);
    rdchk(8'h08, 32'h000c_0000);
  endtask : t_map

  task automatic t_idle;
    wr_rd(8'h08, 32'h0044_0000, 32'h004c_0000);
    chk(idle_insert_enable, 1'b1);
    i_lcb_phy_model.grant_pulse(1);
    #1;
    chk(phy_idle_drive, 1'b1);
    wr(8'h08, 32'h0004_0000);
    i_lcb_phy_model.grant_pulse(2);
    #1;
    chk(phy_idle_drive, 1'b0);
  endtask : t_idle

  task automatic t_selfclr;
    for (int i = 0; i < 2; i++) begin
      wr(8'h08, 32'h0004_0000 | (32'h0010_0000 << i));
      #1;
      chk({transmitter_soft_reset, receiver_soft_reset}, 2'b1 << i);
      tick(1);
      chk({transmitter_soft_reset, receiver_soft_reset}, 2'b00);
      rdchk(8'h08, 32'h000c_0000);
    end
  endtask : t_selfclr

  task automatic t_busclr;
    wr(8'h08, 32'h0005_0000);
    i_lcb_phy_model.bus_reset_pulse(2);
    #1;
    chk(bus_number_clear, 1'b1);
    wr(8'h08, 32'h0004_0000);
    i_lcb_phy_model.bus_reset_pulse(1);
    #1;
    chk(bus_number_clear, 1'b0);
  endtask : t_busclr

  task automatic t_lps;
    logic [4:0] half [4] = '{5'h08, 5'h01, 5'h02, 5'h10};
    logic l;
    int n;
    for (int c = 0; c < 4; c++) begin
      wr(8'h08, 32'h0004_0000 | (c << 14));
      tick(1);
      l = link_power_status_clock;
      while (link_power_status_clock === l) tick(1);
      l = link_power_status_clock;
      n = 0;
      while (link_power_status_clock === l) begin
        tick(1);
        n++;
      end
      chk(n, half[c]);
    end
  endtask : t_lps

  task automatic ack(input logic m, input logic f, input logic w,
      input logic [3:0] e);
    @(posedge hclk);
    async_to_mover <= m;
    async_to_fifo <= f;
    async_is_write <= w;
    @(posedge hclk);
    async_to_mover <= 1'b0;
    async_to_fifo <= 1'b0;
    #1;
    chk(ack_valid, 1'b1);
    chk(ack_code, e);
  endtask : ack

  task automatic t_ack;
    wr(8'h08, 32'h0004_0000);
    ack(1'b1, 1'b0, 1'b1, LCB_ACK_PENDING);
    ack(1'b0, 1'b1, 1'b0, LCB_ACK_PENDING);
    wr(8'h08, 32'h0004_3000);
    ack(1'b1, 1'b0, 1'b1, LCB_ACK_COMPLETE);
    ack(1'b1, 1'b0, 1'b0, LCB_ACK_PENDING);
    ack(1'b0, 1'b1, 1'b0, LCB_ACK_COMPLETE);
  endtask : t_ack

  task automatic t_contender;
    wr(8'h08, 32'h0000_0000);
    tick(1);
    chk({contender_pin_oe, contender_pin_out}, 2'b11);
    wr(8'h08, 32'h0000_0000);
    tick(1);
    chk({contender_pin_oe, contender_pin_out}, 2'b10);
    rdchk(8'h08, 32'h0000_0000);
    i_lcb_phy_model.pin_level <= 1'b0;
    wr(8'h08, 32'h000c_0000);
    tick(2);
    chk(contender_pin_oe, 1'b0);
    rdchk(8'h08, 32'h0004_0000);
  endtask : t_contender

  task automatic tally_and_finish;
    $display("miscompares=%0d samples_checked=%0d", miscompares,
      samples_checked);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #20000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    async_to_mover = 1'b0;
    async_to_fifo = 1'b0;
    async_is_write = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_map();
    t_idle();
    t_selfclr();
    t_busclr();
    t_lps();
    t_ack();
    t_contender();
    tally_and_finish();
  end
endmodule : tb_top
